//--- timing_pkg.sv
/*
  constants for the standard-instruction timing lookup: operation codes,
  operand sizes, destination forms, loop outcomes, addressing modes.
  assumes nothing of its surroundings.
*/
package timing_pkg;

  typedef enum logic [3:0] {
    sum_op = 4'h0,
    difference_op = 4'h1,
    and_op = 4'h2,
    or_op = 4'h3,
    bitwise_parity_op = 4'h4,
    compare_op = 4'h5,
    signed_divide_op = 4'h6,
    unsigned_divide_op = 4'h7,
    multiply_op = 4'h8
  } op_t;

  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_word = 2'h1,
    size_long = 2'h2
  } size_t;

  // destination form: into pointer_register, into value_register, into memory
  typedef enum logic [1:0] {
    dst_pointer = 2'h0,
    dst_value = 2'h1,
    dst_memory = 2'h2
  } dest_t;

  typedef enum logic [1:0] {
    loop_none = 2'h0,
    loop_continued = 2'h1,
    loop_cond_end = 2'h2,
    loop_expired = 2'h3
  } loop_t;

  // computed_operand_location mode
  typedef enum logic [2:0] {
    mode_value_direct = 3'h0,
    mode_pointer_direct = 3'h1,
    mode_indirect = 3'h2,
    mode_postinc = 3'h3,
    mode_predec = 3'h4,
    mode_other = 3'h5
  } mode_t;

  localparam int CLK_W = 8;
  localparam int BUS_W = 3;

  localparam logic [CLK_W-1:0] PREDEC_EXTRA_CLKS = 8'h02;
  localparam logic [CLK_W-1:0] MULTIPLY_MAX_CLKS = 8'h2a;
  localparam logic [CLK_W-1:0] MULTIPLY_REG_CLKS = 8'h28;
  localparam logic [CLK_W-1:0] SIGNED_DIVIDE_CLKS = 8'h7a;
  localparam logic [CLK_W-1:0] UNSIGNED_DIVIDE_CLKS = 8'h6c;

  // base entries, in mclk periods
  localparam logic [CLK_W-1:0] REG_SHORT_CLKS = 8'h04;
  localparam logic [CLK_W-1:0] REG_LONG_CLKS = 8'h06;
  localparam logic [CLK_W-1:0] POINTER_SHORT_CLKS = 8'h08;
  localparam logic [CLK_W-1:0] POINTER_FAST_CLKS = 8'h06;
  localparam logic [CLK_W-1:0] MEM_SHORT_CLKS = 8'h08;
  localparam logic [CLK_W-1:0] MEM_LONG_CLKS = 8'h0c;
  localparam logic [CLK_W-1:0] LOOP_SHORT_CLKS = 8'h10;
  localparam logic [CLK_W-1:0] LOOP_POINTER_SHORT_CLKS = 8'h12;
  localparam logic [CLK_W-1:0] LOOP_LONG_CLKS = 8'h16;
  localparam logic [CLK_W-1:0] LOOP_MEM_LONG_CLKS = 8'h18;
  localparam logic [CLK_W-1:0] LOOP_DIFF_LONG_CLKS = 8'h14;
  localparam logic [CLK_W-1:0] LOOP_CMP_SHORT_CLKS = 8'h0c;
  localparam logic [CLK_W-1:0] LOOP_CMP_LONG_CLKS = 8'h12;
  localparam logic [CLK_W-1:0] COND_END_EXTRA_CLKS = 8'h06;
  localparam logic [CLK_W-1:0] EXPIRED_EXTRA_CLKS = 8'h04;
  localparam logic [CLK_W-1:0] CMP_LONG_EXPIRED_EXTRA_CLKS = 8'h02;

endpackage : timing_pkg

//--- entry_adder.sv
/*
  adds the separate operand-location cost to a table entry, component by
  component. assumes both inputs are valid in the same cycle.
*/
`timescale 1ns/1ps
module entry_adder
  import timing_pkg::*;
(
  // table entry
  input wire logic [CLK_W-1:0] base_clks,
  input wire logic [BUS_W-1:0] base_reads,
  input wire logic [BUS_W-1:0] base_writes,
  input wire logic add_ea,
  // operand-location cost
  input wire logic [CLK_W-1:0] ea_clks,
  input wire logic [BUS_W-1:0] ea_reads,
  input wire logic [BUS_W-1:0] ea_writes,
  // totals
  output logic [CLK_W-1:0] sum_clks,
  output logic [BUS_W-1:0] sum_reads,
  output logic [BUS_W-1:0] sum_writes
);

  always_comb begin
    sum_clks = base_clks;
    sum_reads = base_reads;
    sum_writes = base_writes;
    if (add_ea) begin
      sum_clks = CLK_W'(base_clks + ea_clks);
      sum_reads = BUS_W'(base_reads + ea_reads);
      sum_writes = BUS_W'(base_writes + ea_writes);
    end
  end

endmodule : entry_adder

//--- std_instr_cycle_timing.sv
/*
  standard two-operand instruction timing: looks up clocks, reads and writes
  for one request and then holds a busy window of that many mclk cycles.
  assumes a single 20 MHz mclk and zero-wait bus cycles.
*/
`timescale 1ns/1ps
// What this block does
// - counts cover operation, write-back, next fetch
// - answer is clocks, reads and writes
// - plus entries add location cost componentwise
// - divides 122/108, multiply at most 42
// - register 4 or 6, memory 8 or 12 clocks
// - loop sum 16, 22, 20 clocks
// - predecrement adds two clocks in loop
// - loop accepts only indirect, postinc, predec
// - parity into register needs register source
// - pointer destination forbids byte size
// - immediate counts include operand word fetches
module std_instr_cycle_timing
  import timing_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // request
  input wire logic req_valid,
  input wire op_t req_op,
  input wire size_t req_size,
  input wire dest_t req_dest,
  input wire loop_t req_loop,
  input wire mode_t req_mode,
  input wire logic [CLK_W-1:0] ea_clks,
  input wire logic [BUS_W-1:0] ea_reads,
  input wire logic [BUS_W-1:0] ea_writes,
  // answer
  output logic req_ready,
  output logic res_valid,
  output logic res_illegal,
  output logic [CLK_W-1:0] res_clks,
  output logic [BUS_W-1:0] res_reads,
  output logic [BUS_W-1:0] res_writes,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  // table lookup

  logic [CLK_W-1:0] tb_clks;
  logic [BUS_W-1:0] tb_reads;
  logic [BUS_W-1:0] tb_writes;
  logic tb_add_ea;
  logic tb_illegal;
  logic lng;
  logic loop_ea_ok;

  // counts for one request; every entry already covers execution, write-back and next fetch
  always_comb begin
    lng = (req_size == size_long);
    tb_clks = 8'h00;
    tb_reads = 3'h1;
    tb_writes = 3'h0;
    tb_add_ea = 1'b1;
    if (req_loop == loop_none) begin
      unique case (req_op)
        signed_divide_op: tb_clks = SIGNED_DIVIDE_CLKS;
        unsigned_divide_op: tb_clks = UNSIGNED_DIVIDE_CLKS;
        multiply_op: begin
          // register source has no location cost, so it has its own maximum
          if (req_mode == mode_value_direct) begin
            tb_clks = MULTIPLY_REG_CLKS;
            tb_add_ea = 1'b0;
          end else begin
            tb_clks = MULTIPLY_MAX_CLKS;
          end
        end
        default: begin
          unique case (req_dest)
            dst_pointer: begin
              if (req_op == compare_op || lng) tb_clks = POINTER_FAST_CLKS;
              else tb_clks = POINTER_SHORT_CLKS;
            end
            dst_value: tb_clks = lng ? REG_LONG_CLKS : REG_SHORT_CLKS;
            default: begin
              tb_clks = lng ? MEM_LONG_CLKS : MEM_SHORT_CLKS;
              tb_writes = lng ? 3'h2 : 3'h1;
            end
          endcase
          // a register-only source carries no location cost
          if (req_op == bitwise_parity_op && req_dest == dst_value) tb_add_ea = 1'b0;
        end
      endcase
    end else begin
      // loop entries already hold the operand access, so no location cost
      tb_add_ea = 1'b0;
      tb_reads = lng ? 3'h2 : 3'h1;
      if (req_loop != loop_continued) tb_reads = BUS_W'(tb_reads + 3'h2);
      if (req_dest == dst_memory) tb_writes = lng ? 3'h2 : 3'h1;
      if (req_op == compare_op) begin
        tb_clks = lng ? LOOP_CMP_LONG_CLKS : LOOP_CMP_SHORT_CLKS;
      end else if (lng) begin
        if (req_dest == dst_memory) begin
          tb_clks = LOOP_MEM_LONG_CLKS;
        end else if (req_op == difference_op && req_dest == dst_value) begin
          tb_clks = LOOP_DIFF_LONG_CLKS;
        end else begin
          tb_clks = LOOP_LONG_CLKS;
        end
      end else if (req_dest == dst_pointer) begin
        tb_clks = LOOP_POINTER_SHORT_CLKS;
      end else begin
        tb_clks = LOOP_SHORT_CLKS;
      end
      unique case (req_loop)
        loop_cond_end: tb_clks = CLK_W'(tb_clks + COND_END_EXTRA_CLKS);
        loop_expired: begin
          if (req_op == compare_op && lng) tb_clks = CLK_W'(tb_clks + CMP_LONG_EXPIRED_EXTRA_CLKS);
          else tb_clks = CLK_W'(tb_clks + EXPIRED_EXTRA_CLKS);
        end
        default: tb_clks = tb_clks;
      endcase
      if (req_mode == mode_predec) tb_clks = CLK_W'(tb_clks + PREDEC_EXTRA_CLKS);
    end
  end

  // requests with no entry come back flagged, with no counts and no busy window
  always_comb begin
    tb_illegal = 1'b0;
    loop_ea_ok = (req_mode == mode_indirect || req_mode == mode_postinc || req_mode == mode_predec);
    if (req_loop != loop_none) begin
      if (!loop_ea_ok) begin
        tb_illegal = 1'b1;
      end
      // divide and multiply have no loop-mode entry
      if (req_op >= signed_divide_op) begin
        tb_illegal = 1'b1;
      end
    end
    // checked in and out of loop mode alike
    if (req_op == bitwise_parity_op && req_dest == dst_value && req_mode != mode_value_direct) begin
      tb_illegal = 1'b1;
    end
    if (req_dest == dst_pointer) begin
      if (req_size == size_byte) begin
        tb_illegal = 1'b1;
      end
      if (!(req_op == sum_op || req_op == difference_op || req_op == compare_op)) begin
        tb_illegal = 1'b1;
      end
    end
  end

  logic [CLK_W-1:0] tot_clks;
  logic [BUS_W-1:0] tot_reads;
  logic [BUS_W-1:0] tot_writes;

  // an immediate source brings its operand-word fetches in through the location cost
  entry_adder u_add (
    .base_clks(tb_clks),
    .base_reads(tb_reads),
    .base_writes(tb_writes),
    .add_ea(tb_add_ea),
    .ea_clks(ea_clks),
    .ea_reads(ea_reads),
    .ea_writes(ea_writes),
    .sum_clks(tot_clks),
    .sum_reads(tot_reads),
    .sum_writes(tot_writes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // answer registers and busy window

  logic res_valid_r, res_valid_nxt;
  logic res_illegal_r, res_illegal_nxt;
  logic [CLK_W-1:0] res_clks_r, res_clks_nxt;
  logic [BUS_W-1:0] res_reads_r, res_reads_nxt;
  logic [BUS_W-1:0] res_writes_r, res_writes_nxt;
  logic [CLK_W-1:0] left_r, left_nxt;

  // ready only once the previous window has fully counted down
  assign req_ready = (left_r == 8'h00);

  always_comb begin
    res_valid_nxt = 1'b0;
    res_illegal_nxt = res_illegal_r;
    res_clks_nxt = res_clks_r;
    res_reads_nxt = res_reads_r;
    res_writes_nxt = res_writes_r;
    left_nxt = (left_r != 8'h00) ? CLK_W'(left_r - 8'h01) : left_r;
    if (req_valid && req_ready) begin
      res_valid_nxt = 1'b1;
      res_illegal_nxt = tb_illegal;
      res_clks_nxt = tb_illegal ? 8'h00 : tot_clks;
      res_reads_nxt = tb_illegal ? 3'h0 : tot_reads;
      res_writes_nxt = tb_illegal ? 3'h0 : tot_writes;
      // an illegal request opens no window, so the next may follow at once
      left_nxt = tb_illegal ? 8'h00 : tot_clks;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      res_valid_r <= 1'b0;
      res_illegal_r <= 1'b0;
      res_clks_r <= 8'h00;
      res_reads_r <= 3'h0;
      res_writes_r <= 3'h0;
      left_r <= 8'h00;
    end else begin
      res_valid_r <= res_valid_nxt;
      res_illegal_r <= res_illegal_nxt;
      res_clks_r <= res_clks_nxt;
      res_reads_r <= res_reads_nxt;
      res_writes_r <= res_writes_nxt;
      left_r <= left_nxt;
    end
  end

  assign res_valid = res_valid_r;
  assign res_illegal = res_illegal_r;
  assign res_clks = res_clks_r;
  assign res_reads = res_reads_r;
  assign res_writes = res_writes_r;
  assign busy = (left_r != 8'h00);

endmodule : std_instr_cycle_timing

//--- timing_properties.sv
/* checker on the timing lookup ports.
   assumes a bind from the testbench top, one mclk domain. */
`timescale 1ns/1ps
module timing_properties
  import timing_pkg::*;
(
  // clock and reset
  input wire logic mclk, reset,
  // request
  input wire logic req_valid,
  input wire op_t req_op,
  input wire size_t req_size,
  input wire dest_t req_dest,
  input wire loop_t req_loop,
  input wire mode_t req_mode,
  input wire logic [CLK_W-1:0] ea_clks,
  input wire logic [BUS_W-1:0] ea_reads, ea_writes,
  // answer
  input wire logic req_ready, res_valid, res_illegal,
  input wire logic [CLK_W-1:0] res_clks,
  input wire logic [BUS_W-1:0] res_reads, res_writes,
  input wire logic busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire take = req_valid && req_ready;

  chk_answer_next: assert property (take |=> res_valid)
    else $error("no answer after a taken request");
  chk_no_stray: assert property (!take |=> !res_valid)
    else $error("answer without a request");
  chk_illegal_zero: assert property (res_illegal |-> res_clks == 8'h00 && res_reads == 3'h0)
    else $error("illegal answer carries counts");
  chk_busy_blocks: assert property (res_valid && !res_illegal |-> busy && !req_ready)
    else $error("no busy window after an answer");
  chk_parity_src: assert property (take && req_op == bitwise_parity_op && req_dest == dst_value
    && req_mode != mode_value_direct |=> res_illegal) else $error("parity source accepted");
  chk_pointer_byte: assert property (take && req_dest == dst_pointer && req_size == size_byte
    |=> res_illegal) else $error("byte pointer destination accepted");
  chk_loop_mode: assert property (take && req_loop != loop_none && (req_mode < mode_indirect
    || req_mode > mode_predec) |=> res_illegal) else $error("loop mode accepted");
  chk_divide_clks: assert property (take && req_op == signed_divide_op && req_loop == loop_none
    |=> res_clks == SIGNED_DIVIDE_CLKS + $past(ea_clks)) else $error("signed divide clocks");
  cov_loop: cover property (take && req_loop == loop_expired);
  cov_illegal: cover property (res_valid && res_illegal);
  cov_divide: cover property (take && req_op == unsigned_divide_op);
endmodule : timing_properties

//--- location_cost_source.sv
/* partner model: cost of the computed operand location per mode.
   assumes zero-wait bus cycles. */
`timescale 1ns/1ps
module location_cost_source
  import timing_pkg::*;
(
  input wire mode_t mode,
  output logic [CLK_W-1:0] ea_clks,
  output logic [BUS_W-1:0] ea_reads, ea_writes
);
  always_comb begin
    ea_writes = 3'h0;
    ea_reads = (mode >= mode_indirect) ? 3'h1 : 3'h0;
    case (mode)
      mode_indirect, mode_postinc: ea_clks = 8'h04;
      mode_predec: ea_clks = 8'h06;
      mode_other: begin
        ea_clks = 8'h08;
        ea_reads = 3'h2;
      end
      default: ea_clks = 8'h00;
    endcase
  end
endmodule : location_cost_source

//--- test_std_instr_cycle_timing.sv
/* self-checking bench for the timing lookup.
   assumes the location cost partner feeds the ea inputs. */
`timescale 1ns/1ps
module test_std_instr_cycle_timing;
  import timing_pkg::*;
  logic mclk = 0, reset = 1, req_valid = 0, req_ready, res_valid, res_illegal, busy;
  op_t req_op = sum_op;
  size_t req_size = size_word;
  dest_t req_dest = dst_value;
  loop_t req_loop = loop_none;
  mode_t req_mode = mode_value_direct;
  logic [7:0] ea_clks, res_clks;
  logic [2:0] ea_reads, ea_writes, res_reads, res_writes;
  int failures = 0, tests_run = 0;
  always #25 mclk = ~mclk;
  location_cost_source cost (.mode(req_mode), .ea_clks(ea_clks), .ea_reads(ea_reads), .ea_writes(ea_writes));
  std_instr_cycle_timing dut (
    .mclk(mclk), .reset(reset), .req_valid(req_valid), .req_op(req_op), .req_size(req_size),
    .req_dest(req_dest), .req_loop(req_loop), .req_mode(req_mode), .ea_clks(ea_clks), .ea_reads(ea_reads),
    .ea_writes(ea_writes), .req_ready(req_ready), .res_valid(res_valid), .res_illegal(res_illegal),
    .res_clks(res_clks), .res_reads(res_reads), .res_writes(res_writes), .busy(busy)
  );
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic run(op_t o, size_t s, dest_t d, loop_t l, mode_t m, logic il, logic [7:0] c, logic [2:0] r, w);
    int n;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= o;
    req_size <= s;
    req_dest <= d;
    req_loop <= l;
    req_mode <= m;
    @(posedge mclk);
    req_valid <= 1'b0;
    @(negedge mclk);
    chk({7'h0, res_valid}, 8'h01);
    chk({7'h0, res_illegal}, {7'h0, il});
    chk(res_clks, c);
    chk({5'h0, res_reads}, {5'h0, r});
    chk({5'h0, res_writes}, {5'h0, w});
    for (n = 0; busy === 1'b1 && n < 250; n++) @(negedge mclk);
    chk(n[7:0], c);
  endtask : run
  ////////////////////////////////////////////////////////////////
  task automatic test_register;
    run(sum_op, size_word, dst_value, loop_none, mode_indirect, 0, 8'h08, 3'h2, 3'h0);
    run(difference_op, size_byte, dst_value, loop_none, mode_value_direct, 0, 8'h04, 3'h1, 3'h0);
  endtask : test_register
  task automatic test_memory;
    run(or_op, size_word, dst_memory, loop_none, mode_other, 0, 8'h10, 3'h3, 3'h1);
    run(and_op, size_long, dst_memory, loop_none, mode_indirect, 0, 8'h10, 3'h2, 3'h2);
  endtask : test_memory
  task automatic test_divide;
    run(signed_divide_op, size_word, dst_value, loop_none, mode_indirect, 0, 8'h7e, 3'h2, 3'h0);
    run(unsigned_divide_op, size_word, dst_value, loop_none, mode_indirect, 0, 8'h70, 3'h2, 3'h0);
    run(multiply_op, size_word, dst_value, loop_none, mode_indirect, 0, 8'h2e, 3'h2, 3'h0);
    run(multiply_op, size_word, dst_value, loop_none, mode_value_direct, 0, 8'h28, 3'h1, 3'h0);
  endtask : test_divide
  task automatic test_loop;
    run(sum_op, size_word, dst_value, loop_continued, mode_indirect, 0, 8'h10, 3'h1, 3'h0);
    run(sum_op, size_byte, dst_value, loop_cond_end, mode_postinc, 0, 8'h16, 3'h3, 3'h0);
    run(sum_op, size_word, dst_value, loop_expired, mode_indirect, 0, 8'h14, 3'h3, 3'h0);
    run(sum_op, size_word, dst_value, loop_expired, mode_predec, 0, 8'h16, 3'h3, 3'h0);
  endtask : test_loop
  task automatic test_illegal;
    run(sum_op, size_word, dst_value, loop_continued, mode_value_direct, 1, 8'h00, 3'h0, 3'h0);
    run(bitwise_parity_op, size_word, dst_value, loop_none, mode_indirect, 1, 8'h00, 3'h0, 3'h0);
    run(sum_op, size_byte, dst_pointer, loop_none, mode_value_direct, 1, 8'h00, 3'h0, 3'h0);
  endtask : test_illegal
  task automatic test_other_forms;
    run(compare_op, size_word, dst_pointer, loop_none, mode_pointer_direct, 0, 8'h06, 3'h1, 3'h0);
    run(sum_op, size_long, dst_pointer, loop_none, mode_indirect, 0, 8'h0a, 3'h2, 3'h0);
    run(compare_op, size_long, dst_value, loop_expired, mode_postinc, 0, 8'h14, 3'h4, 3'h0);
    run(difference_op, size_long, dst_value, loop_cond_end, mode_predec, 0, 8'h1c, 3'h4, 3'h0);
    run(or_op, size_word, dst_memory, loop_continued, mode_indirect, 0, 8'h10, 3'h1, 3'h1);
    run(bitwise_parity_op, size_word, dst_value, loop_continued, mode_indirect, 1, 8'h00, 3'h0, 3'h0);
  endtask : test_other_forms
  task automatic test_reset;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= signed_divide_op;
    req_size <= size_word;
    req_dest <= dst_value;
    req_loop <= loop_none;
    req_mode <= mode_indirect;
    @(posedge mclk);
    req_valid <= 1'b0;
    repeat (4) @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk({7'h0, busy}, 8'h00);
    chk({7'h0, req_ready}, 8'h01);
    chk(res_clks, 8'h00);
    run(sum_op, size_word, dst_value, loop_none, mode_indirect, 0, 8'h08, 3'h2, 3'h0);
  endtask : test_reset
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    test_register();
    test_memory();
    test_divide();
    test_loop();
    test_illegal();
    test_other_forms();
    test_reset();
    tally_and_finish();
  end
  initial begin
    #(50 * 5000);
    failures++;
    tally_and_finish();
  end
endmodule : test_std_instr_cycle_timing
bind std_instr_cycle_timing timing_properties props (
  .mclk(mclk), .reset(reset), .req_valid(req_valid), .req_op(req_op), .req_size(req_size),
  .req_dest(req_dest), .req_loop(req_loop), .req_mode(req_mode), .ea_clks(ea_clks), .ea_reads(ea_reads),
  .ea_writes(ea_writes), .req_ready(req_ready), .res_valid(res_valid), .res_illegal(res_illegal),
  .res_clks(res_clks), .res_reads(res_reads), .res_writes(res_writes), .busy(busy)
);
